// *** src/rdw_pkg.sv ***
// shared constants and carriers of the receive descriptor write-back block
package rdw_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_RX_CONTROL = 8'h00;
   localparam logic [7:0] OFF_RX_FILTER = 8'h04;
   localparam logic [7:0] OFF_RX_CSUM = 8'h08;
   localparam logic [7:0] OFF_SPLIT_RX = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   // register fields and reset values
   localparam logic [1:0] DESC_TYPE_SPLIT = 2'h1;
   localparam int CS_START_W = 8;
   localparam int CS_PAYLOAD_EN = 8;
   localparam int CS_L4_OFFLOAD = 9;
   localparam int CS_SUM_DISABLE = 13;
   localparam int BSIZE_W = 8;
   localparam int BSIZE_SHIFT = 7;
   localparam int STAT_BUSY = 16;
   localparam logic [31:0] CSUM_RESET = 32'h0000_0000;
   // write-back field positions
   localparam int ERR_LSB = 20;
   localparam int ERR_W = 12;
   localparam int E_RX_DATA = 11;
   localparam int E_IPV4_SUM = 10;
   localparam int E_L4 = 9;
   localparam int E_CARRIER = 8;
   localparam int E_SEQUENCE = 6;
   localparam int E_SYMBOL = 5;
   localparam int E_CE = 4;
   localparam int ST_W = 20;
   localparam int S_DONE = 0;
   localparam int S_EOP = 1;
   localparam int S_VP = 3;
   localparam int S_UDP_SUM = 4;
   localparam int S_TCP_SUM = 5;
   localparam int S_IPCS = 6;
   localparam int S_IDENT_VALID = 9;
   localparam int S_UDP_VALID = 10;
   localparam int S_PTYPE = 16;
   localparam int LEN_LSB = 32;
   localparam int VLAN_LSB = 48;
   localparam int HSP_BIT = 15;
   localparam int HDR_LEN_W = 10;
   localparam logic [2:0] QW_EXT = 3'h2;
   localparam logic [2:0] QW_SPLIT = 3'h4;

   // per-descriptor packet facts from the receive parser
   typedef struct packed {
      logic [15:0] length;
      logic [15:0] vlan;
      logic [15:0] pkt_sum;
      logic [15:0] payload_sum;
      logic [15:0] ip_ident;
      logic [31:0] alt_content;
      logic [9:0] hdr_len;
      logic [3:0] pkt_type;
      logic rx_err, ipv4_err, l4_err, cext_err, sequence_err, sym_err, crc_err;
      logic eop, vlan_present, ipv4, ipv4_sum_done, fragmented;
      logic has_tcp, has_udp, udp_sum_nonzero, split_capable, continuation;
   } rdw_pkt_s;

   // fetched descriptor buffer pointers
   typedef struct packed {
      logic [3:0][63:0] buf_addr;
   } rdw_desc_s;

   // write-back image plus per-buffer posting plan
   typedef struct packed {
      logic [3:0][63:0] qw;
      logic [2:0] qw_count;
      logic [3:0][15:0] buf_len;
      logic [3:0] buf_write;
      logic [3:0][63:0] buf_addr;
   } rdw_wb_s;

   typedef enum logic {ST_IDLE, ST_SEND} rdw_state_e;
endpackage

// *** src/rdw_writeback.sv ***
// receive descriptor write-back and packet-split buffer planner
// How it works
// (R1) 12-bit error field at quadword 1 bit 20
// (R2) error bits 11..8: data, ipv4, l4, carrier
// (R3) bits 6..4 sequence, symbol, crc; rest reserved
// (R4) length at bit 32, vlan at bit 48
// (R5) driver clears disable, sets payload sum, start zero
// (R6) checksum and ident fields only while disable clear
// (R7) unfragmented ipv4: no ident; offload flags per setting
// (R8) fragments: payload sum, ident, udp flags
// (R9) driver expects all-ones sum over fragments
// (R10) split format needs extended enable and type 01
// (R11) four pointers; capacities from split control sizes
// (R12) driver keeps buffer pointers word aligned
// (R13) header larger than buffer 0 means no split
// (R14) zero-size buffers are never written
// (R15) continuation descriptors leave buffer 0 unused
// (R16) driver keeps pointer 1 bit 0 zero
// (R17) per-buffer lengths at 8.32 and 16.16
// (R18) unused buffers report zero length
// (R19) lengths count every stored byte incl. crc
// (R20) driver checks every buffer length
// (R21) header status word: split flag, header length
// (R22) done flag set in every write-back
// (R23) reserved bits written as zero
`timescale 1ns/100ps
module rdw_writeback #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // packet and descriptor request
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire rdw_pkg::rdw_pkt_s pkt,
   input wire rdw_pkg::rdw_desc_s desc,
   // write-back toward the bus master
   output logic wb_valid,
   input wire logic wb_ready,
   output rdw_pkg::rdw_wb_s wb
);
   logic [1:0] desc_type_ff;
   logic ext_en_ff;
   logic [31:0] csum_ctl_ff;
   logic [3:0][rdw_pkg::BSIZE_W-1:0] split_size_ff;
   logic [15:0] wb_count_ff;
   logic [31:0] prdata_ff;
   logic err_ff;
   rdw_pkg::rdw_state_e state_ff;
   rdw_pkg::rdw_wb_s wb_ff;
   rdw_pkg::rdw_wb_s nxt_wb;
   logic [31:0] rd_mux;
   logic hit;
   logic wr_acc;
   logic take;
   logic split_mode;
   logic frag_mode;
   logic frag;
   logic do_split;
   logic [15:0] cap0;
   logic [15:0] cap;
   logic [15:0] rem;
   logic [3:0][15:0] len;
   logic [rdw_pkg::ERR_W-1:0] eb;
   logic [rdw_pkg::ST_W-1:0] st;
   logic [15:0] csum;
   logic [15:0] ipid;
   logic [9:0] hdr_status_len;
   logic [3:0] size_zero;

   // zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = err_ff & psel & penable;
   assign wr_acc = psel & penable & pwrite & ~err_ff;
   assign take = pkt_valid & pkt_ready;
   assign pkt_ready = (state_ff == rdw_pkg::ST_IDLE);
   assign wb_valid = (state_ff == rdw_pkg::ST_SEND);
   assign wb = wb_ff;

   // format and checksum mode decode
   assign split_mode = ext_en_ff
      & (desc_type_ff == rdw_pkg::DESC_TYPE_SPLIT); // R10
   assign frag_mode = ~csum_ctl_ff[rdw_pkg::CS_SUM_DISABLE]
      & csum_ctl_ff[rdw_pkg::CS_PAYLOAD_EN]
      & (csum_ctl_ff[rdw_pkg::CS_START_W-1:0] == '0);
   assign frag = pkt.ipv4 & pkt.fragmented;
   assign cap0 = 16'(split_size_ff[0]) << rdw_pkg::BSIZE_SHIFT; // R11
   // headers never straddle buffers, so a short buffer 0 disables split
   assign do_split = split_mode & pkt.split_capable & ~pkt.continuation
      & (cap0 >= 16'(pkt.hdr_len)); // R13

   // address decode and read mux
   always_comb begin
      hit = 1'b1;
      rd_mux = '0;
      unique case (paddr[7:0])
         rdw_pkg::OFF_RX_CONTROL: rd_mux[1:0] = desc_type_ff;
         rdw_pkg::OFF_RX_FILTER: rd_mux[0] = ext_en_ff;
         rdw_pkg::OFF_RX_CSUM: rd_mux = csum_ctl_ff;
         rdw_pkg::OFF_SPLIT_RX: rd_mux = split_size_ff;
         rdw_pkg::OFF_STATUS: begin
            rd_mux[15:0] = wb_count_ff;
            rd_mux[rdw_pkg::STAT_BUSY] = wb_valid;
         end
         default: hit = 1'b0;
      endcase
   end

   // read data and error latched in setup so they stand in access
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prdata_ff <= 32'h0;
         err_ff <= 1'b0;
      end else if (psel & ~penable) begin
         prdata_ff <= pwrite ? 32'h0 : rd_mux;
         err_ff <= ~hit | (pwrite & (paddr[7:0] == rdw_pkg::OFF_STATUS));
      end
   end

   // software configuration registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         desc_type_ff <= 2'h0;
         ext_en_ff <= 1'b0;
         csum_ctl_ff <= rdw_pkg::CSUM_RESET;
         split_size_ff <= '0;
      end else if (wr_acc) begin
         unique case (paddr[7:0])
            rdw_pkg::OFF_RX_CONTROL: desc_type_ff <= pwdata[1:0];
            rdw_pkg::OFF_RX_FILTER: ext_en_ff <= pwdata[0];
            rdw_pkg::OFF_RX_CSUM: csum_ctl_ff <= pwdata;
            rdw_pkg::OFF_SPLIT_RX: split_size_ff <= pwdata;
            default: ;
         endcase
      end
   end

   // error and status fields of the write-back
   always_comb begin
      eb = '0; // R23
      eb[rdw_pkg::E_RX_DATA] = pkt.rx_err; // R2
      eb[rdw_pkg::E_IPV4_SUM] = pkt.ipv4_err;
      eb[rdw_pkg::E_L4] = pkt.l4_err;
      eb[rdw_pkg::E_CARRIER] = pkt.cext_err;
      eb[rdw_pkg::E_SEQUENCE] = pkt.sequence_err; // R3
      eb[rdw_pkg::E_SYMBOL] = pkt.sym_err;
      eb[rdw_pkg::E_CE] = pkt.crc_err;
      st = '0;
      st[rdw_pkg::S_DONE] = 1'b1; // R22
      st[rdw_pkg::S_EOP] = pkt.eop;
      st[rdw_pkg::S_VP] = pkt.vlan_present;
      st[rdw_pkg::S_IPCS] = pkt.ipv4 & pkt.ipv4_sum_done;
      st[rdw_pkg::S_PTYPE +: 4] = pkt.pkt_type;
      if (frag) begin
         st[rdw_pkg::S_IDENT_VALID] = 1'b1; // R8
         if (~pkt.has_tcp & frag_mode) begin
            st[rdw_pkg::S_UDP_SUM] = 1'b1; // R8
            st[rdw_pkg::S_UDP_VALID] = pkt.has_udp & pkt.udp_sum_nonzero;
         end
      end else if (pkt.ipv4 & csum_ctl_ff[rdw_pkg::CS_L4_OFFLOAD]) begin
         st[rdw_pkg::S_TCP_SUM] = pkt.has_tcp | pkt.has_udp; // R7
         st[rdw_pkg::S_UDP_SUM] = pkt.has_udp;
      end
      // ident only meaningful for fragments; zero otherwise
      ipid = frag ? pkt.ip_ident : 16'h0; // R7
      csum = (frag & ~pkt.has_tcp & frag_mode) ? pkt.payload_sum
         : pkt.pkt_sum; // R8
   end

   // buffer fill: header to buffer 0, then data in order, capped by size;
   // bytes beyond the last buffer are the fetch side's concern
   always_comb begin
      rem = pkt.length; // R19
      cap = '0;
      len = '0;
      for (int i = 0; i < 4; i++) begin
         cap = 16'(split_size_ff[i]) << rdw_pkg::BSIZE_SHIFT; // R11
         if (!split_mode) begin
            len[i] = (i == 0) ? rem : 16'h0;
         end else if (i == 0 && pkt.continuation) begin
            len[i] = 16'h0; // R15
         end else if (i == 0 && do_split) begin
            len[i] = 16'(pkt.hdr_len); // R21
         end else if (cap == 16'h0) begin
            len[i] = 16'h0; // R14
         end else begin
            len[i] = (rem < cap) ? rem : cap;
         end
         rem = rem - len[i];
      end
      hdr_status_len = do_split ? pkt.hdr_len : 10'h0;
   end

   // assemble the descriptor image
   always_comb begin
      nxt_wb = '0; // R23
      if (csum_ctl_ff[rdw_pkg::CS_SUM_DISABLE]) begin
         nxt_wb.qw[0][63:32] = pkt.alt_content; // R6
      end else begin
         nxt_wb.qw[0][63:32] = {csum, ipid}; // R6
      end
      nxt_wb.qw[1][rdw_pkg::VLAN_LSB +: 16] = pkt.vlan; // R4
      nxt_wb.qw[1][rdw_pkg::LEN_LSB +: 16] = len[0]; // R17
      nxt_wb.qw[1][rdw_pkg::ERR_LSB +: rdw_pkg::ERR_W] = eb; // R1
      nxt_wb.qw[1][rdw_pkg::ST_W-1:0] = st;
      if (split_mode) begin
         nxt_wb.qw[2][63:16] = {len[3], len[2], len[1]}; // R17
         nxt_wb.qw[2][rdw_pkg::HSP_BIT] = do_split; // R21
         nxt_wb.qw[2][rdw_pkg::HDR_LEN_W-1:0] = hdr_status_len;
      end
      nxt_wb.qw_count = split_mode ? rdw_pkg::QW_SPLIT : rdw_pkg::QW_EXT;
      nxt_wb.buf_len = len; // R18
      for (int i = 0; i < 4; i++) begin
         nxt_wb.buf_write[i] = (len[i] != 16'h0); // R14
      end
      nxt_wb.buf_addr = desc.buf_addr; // R11
   end

   // request/answer sequencing: one descriptor in flight
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= rdw_pkg::ST_IDLE;
      end else begin
         unique case (state_ff)
            rdw_pkg::ST_IDLE: if (take) state_ff <= rdw_pkg::ST_SEND;
            rdw_pkg::ST_SEND: if (wb_ready) state_ff <= rdw_pkg::ST_IDLE;
         endcase
      end
   end

   // image captured at acceptance, held stable while stalled
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wb_ff <= '0;
      end else if (take) begin
         wb_ff <= nxt_wb;
      end
   end

   // completed write-back counter, wraps
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wb_count_ff <= 16'h0;
      end else if (wb_valid & wb_ready) begin
         wb_count_ff <= wb_count_ff + 16'h1;
      end
   end

   // checks
   sequence s_take;
      pkt_valid && pkt_ready;
   endsequence
   sequence s_take_frag;
      s_take ##0 (pkt.ipv4 && pkt.fragmented && !pkt.has_tcp && frag_mode);
   endsequence
   sequence s_take_whole;
      s_take ##0 (pkt.ipv4 && !pkt.fragmented);
   endsequence

   property p_err_rsvd;
      @(posedge clock) disable iff (!rst_b)
      wb_valid |-> (wb.qw[1][27] == 1'b0) && (wb.qw[1][23:20] == 4'h0);
   endproperty
   a_err_rsvd: assert property (p_err_rsvd) // R3
      else $error("reserved error bits not zero");

   property p_crc_map;
      @(posedge clock) disable iff (!rst_b)
      s_take |=> wb.qw[1][24] == $past(pkt.crc_err)
         && wb.qw[1][31] == $past(pkt.rx_err);
   endproperty
   a_crc_map: assert property (p_crc_map) // R1
      else $error("error bit placement wrong");

   property p_done;
      @(posedge clock) disable iff (!rst_b)
      wb_valid |-> wb.qw[1][0];
   endproperty
   a_done: assert property (p_done) // R22
      else $error("done flag missing");

   property p_frag;
      @(posedge clock) disable iff (!rst_b)
      s_take_frag |=> wb_valid && wb.qw[1][9] && wb.qw[1][4]
         && wb.qw[0][63:48] == $past(pkt.payload_sum);
   endproperty
   a_frag: assert property (p_frag) // R8
      else $error("fragment checksum fields wrong");

   property p_whole;
      @(posedge clock) disable iff (!rst_b)
      s_take_whole |=> !wb.qw[1][9] && !wb.qw[1][10]
         && (wb.qw[0][47:32] == 16'h0
         || wb.qw[0][47:32] == $past(pkt.alt_content[15:0]));
   endproperty
   a_whole: assert property (p_whole) // R7
      else $error("unfragmented packet flagged as fragment");

   property p_zero_len;
      @(posedge clock) disable iff (!rst_b)
      s_take ##0 !split_mode |=> wb.buf_len[3:1] == '0 && wb.qw[2] == '0
         && wb.qw[1][47:32] == $past(pkt.length);
   endproperty
   a_zero_len: assert property (p_zero_len) // R18
      else $error("unused buffer length not zero");

   // per-buffer flag of a zero configured size
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         size_zero[i] = (split_size_ff[i] == '0);
      end
   end

   property p_zero_size;
      @(posedge clock) disable iff (!rst_b)
      s_take ##0 split_mode |=> (wb.buf_write & $past(size_zero)) == 4'h0;
   endproperty
   a_zero_size: assert property (p_zero_size) // R14
      else $error("zero-size buffer marked for writing");

   property p_split_len;
      @(posedge clock) disable iff (!rst_b)
      wb_valid && wb.qw_count == rdw_pkg::QW_SPLIT |->
         wb.qw[2][31:16] == wb.buf_len[1] && wb.qw[2][63:48] == wb.buf_len[3]
         && wb.qw[1][47:32] == wb.buf_len[0];
   endproperty
   a_split_len: assert property (p_split_len) // R17
      else $error("split lengths misplaced");

   property p_cont;
      @(posedge clock) disable iff (!rst_b)
      s_take ##0 (split_mode && pkt.continuation) |=> wb.buf_len[0] == 16'h0
         && !wb.buf_write[0];
   endproperty
   a_cont: assert property (p_cont) // R15
      else $error("continuation used buffer 0");

   property p_hold;
      @(posedge clock) disable iff (!rst_b)
      wb_valid && !wb_ready |=> wb_valid && $stable(wb);
   endproperty
   a_hold: assert property (p_hold) // R11
      else $error("write-back changed while stalled");

   property p_no_split;
      @(posedge clock) disable iff (!rst_b)
      s_take ##0 (16'(pkt.hdr_len) > cap0) |=> !wb.qw[2][15];
   endproperty
   a_no_split: assert property (p_no_split) // R13
      else $error("split with oversize header");
endmodule

// *** verification/rdw_host_model.sv ***
// host side model that takes write-backs after a set stall
`timescale 1ns/100ps
module rdw_host_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // write-back channel
   input wire logic wb_valid,
   input wire rdw_pkg::rdw_wb_s wb,
   output logic wb_ready,
   // stall setting and captured image
   input wire logic [3:0] stall,
   output rdw_pkg::rdw_wb_s img_ff,
   output logic [15:0] got_ff
);
   logic [3:0] wait_ff;

   // ready only after the stall, like a busy memory path
   assign wb_ready = wb_valid && (wait_ff >= stall);

   // stall counter, cleared once each image is taken
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         wait_ff <= 4'h0;
      else if (!wb_valid || wb_ready)
         wait_ff <= 4'h0;
      else
         wait_ff <= wait_ff + 4'h1;
   end

   // whole image kept so every buffer length gets inspected
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         img_ff <= '0;
         got_ff <= 16'h0000;
      end else if (wb_valid && wb_ready) begin
         img_ff <= wb;
         got_ff <= got_ff + 16'h0001;
      end
   end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the descriptor write-back block
`timescale 1ns/100ps
module testbench;
   logic clock, rst_b, psel, penable, pwrite, pkt_valid;
   logic pready, pslverr, pkt_ready, wb_valid, wb_ready, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] got;
   logic [3:0] stall;
   rdw_pkg::rdw_pkt_s pkt, p;
   rdw_pkg::rdw_desc_s desc;
   rdw_pkg::rdw_wb_s wb, img;
   int failures, n_compared, n_sent;

   rdw_writeback #(.ADDR_W(8)) i_rdw_writeback (.clock(clock),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
      .pkt(pkt), .desc(desc), .wb_valid(wb_valid), .wb_ready(wb_ready),
      .wb(wb));
   rdw_host_model i_rdw_host_model (.clock(clock), .rst_b(rst_b),
      .wb_valid(wb_valid), .wb(wb), .wb_ready(wb_ready), .stall(stall),
      .img_ff(img), .got_ff(got));

   // 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // hand one packet over and wait for the host to take its image
   task automatic send(input rdw_pkg::rdw_pkt_s x);
      logic [15:0] g0;
      g0 = got;
      @(posedge clock);
      pkt <= x;
      pkt_valid <= 1'b1;
      do @(posedge clock); while (pkt_ready !== 1'b1);
      pkt_valid <= 1'b0;
      n_sent++;
      @(posedge clock);
      chk("busy", 64'h0, 64'(pkt_ready));
      for (int i = 0; i < 40 && got == g0; i++) @(posedge clock);
      chk("taken", 64'(g0 + 16'h1), 64'(got));
   endtask

   task automatic t_regs;
      apb(1'b0, rdw_pkg::OFF_RX_CSUM, 32'h0);
      chk("csum rst", 64'(rdw_pkg::CSUM_RESET), 64'(rd));
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", 64'h1, 64'(er));
      apb(1'b1, rdw_pkg::OFF_STATUS, 32'hffff);
      chk("ro write", 64'h1, 64'(er));
   endtask

   task automatic t_ext;
      p = '0;
      p.length = 16'h05ee;
      p.vlan = 16'h0abc;
      p.vlan_present = 1'b1;
      p.eop = 1'b1;
      p.ipv4 = 1'b1;
      p.ipv4_sum_done = 1'b1;
      p.pkt_type = 4'h2;
      {p.rx_err, p.ipv4_err, p.l4_err, p.cext_err, p.sequence_err, p.sym_err,
         p.crc_err} = 7'h7f;
      send(p);
      chk("err", 64'hf70, 64'(img.qw[1][31:20]));
      chk("len vlan", 64'h0abc_05ee, 64'(img.qw[1][63:32]));
      chk("done", 64'h1, 64'(img.qw[1][rdw_pkg::S_DONE]));
      chk("status", 64'h2004b, 64'(img.qw[1][19:0]));
      chk("addr 3", 64'h4000, img.buf_addr[3]);
      chk("addr 1", 64'h2000, img.buf_addr[1]);
      chk("rsvd", 64'h0, img.qw[2] | img.qw[3] | 64'(img.qw[0][31:0]));
   endtask

   task automatic t_frag;
      logic [15:0] s0;
      logic [16:0] acc;
      apb(1'b1, rdw_pkg::OFF_RX_CSUM, 32'h100);
      p = '0;
      p.length = 16'h0100;
      p.ipv4 = 1'b1;
      p.fragmented = 1'b1;
      p.has_udp = 1'b1;
      p.udp_sum_nonzero = 1'b1;
      p.payload_sum = 16'h1234;
      p.ip_ident = 16'h5678;
      p.pkt_sum = 16'h9999;
      p.alt_content = 32'hcafe_f00d;
      send(p);
      chk("frag sum", 64'h1234_5678, 64'(img.qw[0][63:32]));
      chk("frag flg", 64'hd, 64'({img.qw[1][10:9], img.qw[1][5:4]}));
      s0 = img.qw[0][63:48];
      // second fragment whose payload sum completes the all-ones total
      p.udp_sum_nonzero = 1'b0;
      p.payload_sum = 16'hedcb;
      send(p);
      chk("no udp valid", 64'h1, 64'(img.qw[1][10:9]));
      acc = 17'(s0) + 17'(img.qw[0][63:48]);
      chk("frag total", 64'hffff, 64'(acc[15:0] + 16'(acc[16])));
      // non-fragment with transport offload on
      apb(1'b1, rdw_pkg::OFF_RX_CSUM, 32'h300);
      p.fragmented = 1'b0;
      send(p);
      chk("nf sum", 64'h9999_0000, 64'(img.qw[0][63:32]));
      chk("nf flg", 64'h3, 64'({img.qw[1][10:9], img.qw[1][5:4]}));
      apb(1'b1, rdw_pkg::OFF_RX_CSUM, 32'h2100);
      send(p);
      chk("alt", 64'hcafe_f00d, 64'(img.qw[0][63:32]));
      apb(1'b0, rdw_pkg::OFF_RX_CSUM, 32'h0);
      chk("csum rd", 64'h2100, 64'(rd));
   endtask

   task automatic split_case(input logic [9:0] h, input logic c,
      input logic [15:0] n, input logic [63:0] e, input logic [15:0] hs);
      p = '0;
      p.length = n;
      p.hdr_len = h;
      p.split_capable = 1'b1;
      p.continuation = c;
      send(p);
      chk("qw cnt", 64'(rdw_pkg::QW_SPLIT), 64'(img.qw_count));
      chk("buf len", e, img.buf_len);
      chk("wb len", e, {img.qw[2][63:16], img.qw[1][47:32]});
      chk("hdr st", 64'(hs), 64'(img.qw[2][15:0]));
      chk("no wr", 64'h0, 64'(img.buf_write[3]));
   endtask

   task automatic t_split;
      apb(1'b1, rdw_pkg::OFF_RX_FILTER, 32'h1);
      apb(1'b1, rdw_pkg::OFF_RX_CONTROL, 32'h1);
      apb(1'b1, rdw_pkg::OFF_SPLIT_RX, 32'h0001_0201);
      split_case(10'd64, 1'b0, 16'd400, 64'h0000_0050_0100_0040, 16'h8040);
      split_case(10'd200, 1'b0, 16'd400, 64'h0000_0010_0100_0080, 16'h0);
      split_case(10'd64, 1'b1, 16'd300, 64'h0000_002c_0100_0000, 16'h0);
      split_case(10'd64, 1'b0, 16'd600, 64'h0000_0080_0100_0040, 16'h8040);
      for (int t = 0; t < 4; t++) begin
         apb(1'b1, rdw_pkg::OFF_RX_CONTROL, 32'(t));
         send(p);
         chk("type", (t == 1) ? 64'(rdw_pkg::QW_SPLIT) :
            64'(rdw_pkg::QW_EXT), 64'(img.qw_count));
      end
      apb(1'b1, rdw_pkg::OFF_RX_FILTER, 32'h0);
      apb(1'b1, rdw_pkg::OFF_RX_CONTROL, 32'h1);
      send(p);
      chk("no ext", 64'(rdw_pkg::QW_EXT), 64'(img.qw_count));
   endtask

   task automatic report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog: far beyond the fewer than two hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      report_and_stop;
   end

   // main sequence; slow host during the split tests
   initial begin
      failures = 0;
      n_compared = 0;
      n_sent = 0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pkt_valid = 1'b0;
      pkt = '0;
      stall = 4'h0;
      desc.buf_addr = {64'h4000, 64'h3000, 64'h2000, 64'h1000};
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      t_regs;
      t_ext;
      t_frag;
      stall <= 4'h3;
      t_split;
      apb(1'b0, rdw_pkg::OFF_STATUS, 32'h0);
      chk("wb count", 64'(n_sent), 64'(rd[16:0]));
      report_and_stop;
   end
endmodule
